/* shared/lpsl_consts.vh */
// Purpose: Shared constants for the sixteen-channel grayscale PWM shift/latch block
// Assumes: 100 MHz core clock, all pins sampled into that domain
// Notes:   Times are in ns; cycle counts are derived from them
`ifndef LPSL_CONSTS_VH
`define LPSL_CONSTS_VH
`define LPSL_NUM_CH        16
`define LPSL_GS_W          16
`define LPSL_FRAME_BITS    256
`define LPSL_CLK_PERIOD_NS 10
`define LPSL_DELAY_5V_NS   20
`define LPSL_DELAY_3V3_NS  30
`define LPSL_DELAY_5V_CYC  ((`LPSL_DELAY_5V_NS + `LPSL_CLK_PERIOD_NS - 1) / `LPSL_CLK_PERIOD_NS)
`define LPSL_DELAY_3V3_CYC ((`LPSL_DELAY_3V3_NS + `LPSL_CLK_PERIOD_NS - 1) / `LPSL_CLK_PERIOD_NS)
`define LPSL_OSC_DIV       4
`define LPSL_FIFO_DEPTH    16
`define LPSL_FIFO_AW       4
`define LPSL_RST_MODE_ONE  1'b0
`define LPSL_RST_MODE_FALL 1'b0
`define LPSL_RST_MODE_EXT  1'b0
`endif

/* hdl/lpsl_fifo.v */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes:   One word may pass per cycle; full and empty are exact
`timescale 1ns/10ps
module lpsl_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // Storage words
  reg [AW-1:0]    wp_q;               // Write pointer
  reg [AW-1:0]    rp_q;               // Read pointer
  reg [AW:0]      cnt_q;              // Fill level
  wire            push;
  wire            pop;

  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign rd_data_out  = mem_q[rp_q];
  assign push = wr_valid_in & wr_ready_out;
  assign pop  = rd_valid_out & rd_ready_in;

  // Storage has no reset; pointers guard stale words
  always @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  // Pointer and level bookkeeping
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // lpsl_fifo

/* hdl/lpsl_top.v */
// Purpose: Sixteen-channel grayscale PWM logic with serial shift, latch and chain output
// Assumes: All pins asynchronous to clk_in; shift clock well below clk_in / 4
// Notes:   Channel sinks are open-drain: enable low means the sink conducts
// Behaviour
// - Sixteen channels, each 16-bit grayscale value
// - Shift in data on shift clock rise
// - Latch transparent while strobe high, else hold
// - Strobe high forces outputs off, counter reset
// - Rising-edge mode updates serial output on rise
// - Falling-edge mode updates serial output on fall
// - Grayscale clock pin advances counter when selected
// - Repeating/single cycles, internal/external clock selectable
// - Open-load detection records per-channel error status
// - Stagger channel switching by unit delay step
// - MSB first, channel 15 down to 0
// - Shift out latched words, LSB replaced by flag
// - Single mode: idle after each cycle, next tick restarts it
// - Reset defaults: repeat, rising edge, internal clock
`timescale 1ns/10ps
`include "lpsl_consts.vh"
module lpsl_top (
  input  wire        clk_in,
  input  wire        rst_b_in,
  input  wire        serial_data_in,
  input  wire        shift_clock_in,
  input  wire        latch_strobe_in,
  input  wire        grayscale_clock_in,
  input  wire        falling_edge_out_mode_in,
  input  wire        single_cycle_mode_in,
  input  wire        external_counter_clock_mode_in,
  input  wire        low_supply_in,
  input  wire [15:0] open_sense_in,
  output reg         serial_data_out,
  output wire [15:0] channel_sinks_oe_b_out,
  output wire [15:0] channel_sinks_out,
  output wire [15:0] open_error_out,
  output wire        frame_overflow_out
);
  localparam NCH = `LPSL_NUM_CH;
  localparam GW  = `LPSL_GS_W;
  localparam FB  = `LPSL_FRAME_BITS;
  localparam [1:0] ST_IDLE = 2'b01;  // Waiting for a cycle start
  localparam [1:0] ST_RUN  = 2'b10;  // Counting through a cycle

  // Three-stage samplers: stage 1 only feeds stage 2
  reg  [2:0] dck_s_q, lat_s_q, gck_s_q, dai_s_q;
  reg        dck_v_q, lat_v_q, gck_v_q;     // Filtered levels
  reg  [15:0] osn_a_q, osn_b_q;             // Open-sense synchroniser
  wire       dck_rise, dck_fall, lat_fall, gck_rise;
  wire       dck_ok = (dck_s_q[2] == dck_s_q[1]);
  wire       lat_ok = (lat_s_q[2] == lat_s_q[1]);
  wire       gck_ok = (gck_s_q[2] == gck_s_q[1]);

  assign dck_rise = dck_ok & dck_s_q[1] & ~dck_v_q;
  assign dck_fall = dck_ok & ~dck_s_q[1] & dck_v_q;
  assign lat_fall = lat_ok & ~lat_s_q[1] & lat_v_q;
  assign gck_rise = gck_ok & gck_s_q[1] & ~gck_v_q;

  // Pin sampling; a change counts once stages two and three agree
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dck_s_q <= 3'h0;
      lat_s_q <= 3'h0;
      gck_s_q <= 3'h0;
      dai_s_q <= 3'h0;
      dck_v_q <= 1'b0;
      lat_v_q <= 1'b0;
      gck_v_q <= 1'b0;
      osn_a_q <= 16'h0000;
      osn_b_q <= 16'h0000;
    end
    else
    begin
      dck_s_q <= {dck_s_q[1:0], shift_clock_in};
      lat_s_q <= {lat_s_q[1:0], latch_strobe_in};
      gck_s_q <= {gck_s_q[1:0], grayscale_clock_in};
      dai_s_q <= {dai_s_q[1:0], serial_data_in};
      osn_a_q <= open_sense_in;
      osn_b_q <= osn_a_q;
      if (dck_ok)
        dck_v_q <= dck_s_q[1];
      if (lat_ok)
        lat_v_q <= lat_s_q[1];
      if (gck_ok)
        gck_v_q <= gck_s_q[1];
    end
  end

  // Mode bits, caught at the strobe's fall so a cycle never changes mid-way
  reg mode_one_q, mode_fall_q, mode_ext_q;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_one_q  <= `LPSL_RST_MODE_ONE;
      mode_fall_q <= `LPSL_RST_MODE_FALL;
      mode_ext_q  <= `LPSL_RST_MODE_EXT;
    end
    else if (lat_fall)
    begin
      mode_one_q  <= single_cycle_mode_in;
      mode_fall_q <= falling_edge_out_mode_in;
      mode_ext_q  <= external_counter_clock_mode_in;
    end
  end

  // Shift register: 256 bits, MSB of channel 15 enters first
  reg  [FB-1:0]  sh_q;
  reg  [FB-1:0]  lat_q;       // Latched grayscale words
  reg  [NCH-1:0] err_ok_q;    // One means load present
  reg            reload_q;    // Reload shift chain with status after latch
  wire [FB-1:0]  status_img;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : g_img
      assign status_img[gi*GW +: GW] = {lat_q[gi*GW+1 +: GW-1], err_ok_q[gi]};
    end
  endgenerate

  // Shift, latch and readback loading
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sh_q     <= {FB{1'b0}};
      lat_q    <= {FB{1'b0}};
      reload_q <= 1'b0;
    end
    else
    begin
      if (lat_v_q)
        lat_q <= sh_q;
      reload_q <= lat_fall;
      if (reload_q)
        sh_q <= status_img;
      else if (dck_rise)
        sh_q <= {sh_q[FB-2:0], dai_s_q[2]};
    end
  end

  // Chain output follows the top bit on the selected shift clock edge
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      serial_data_out <= 1'b0;
    else if (reload_q)
      serial_data_out <= status_img[FB-1];
    else if (!mode_fall_q && dck_rise)
      serial_data_out <= sh_q[FB-2];
    else if (mode_fall_q && dck_fall)
      serial_data_out <= sh_q[FB-1];
  end

  // Open-load status: sampled while a channel conducts
  reg [NCH-1:0] on_q;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      err_ok_q <= {NCH{1'b1}};
    else
      err_ok_q <= (err_ok_q & ~(on_q & osn_b_q)) | (on_q & ~osn_b_q);
  end
  assign open_error_out = ~err_ok_q;

  // Internal oscillator: divided core clock
  reg [1:0] osc_q;
  wire      osc_tick = (osc_q == 2'(`LPSL_OSC_DIV - 1));
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      osc_q <= 2'h0;
    else
      osc_q <= osc_tick ? 2'h0 : osc_q + 2'h1;
  end

  wire tick = mode_ext_q ? gck_rise : osc_tick;

  // Grayscale counter and cycle control
  reg [1:0]    st_q;
  reg [GW-1:0] cnt_q;
  reg          active_q;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= {GW{1'b0}};
      active_q <= 1'b0;
    end
    else if (lat_v_q)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= {GW{1'b0}};
      active_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (tick)
          begin
            st_q     <= ST_RUN;
            cnt_q    <= {GW{1'b0}};
            active_q <= 1'b1;
          end
        end
        ST_RUN:
        begin
          if (tick)
          begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == {GW{1'b1}} && mode_one_q)
            begin
              st_q     <= ST_IDLE;
              active_q <= 1'b0;
            end
          end
        end
        default:
        begin
          st_q     <= ST_IDLE;
          active_q <= 1'b0;
        end
      endcase
    end
  end

  // Compare per channel, then stagger through a FIFO-fed delay line
  reg [NCH-1:0] cmp;
  integer k;
  always @*
  begin
    cmp = {NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1)
      cmp[k] = active_q & ~lat_v_q & (cnt_q < lat_q[k*GW +: GW]);
  end

  // FIFO carries the compare words in order; drain is steady
  wire [NCH-1:0] fifo_dat;
  wire           fifo_v;
  wire           fifo_rdy;
  lpsl_fifo #(
    .WIDTH (NCH),
    .DEPTH (`LPSL_FIFO_DEPTH),
    .AW    (`LPSL_FIFO_AW)
  ) u_fifo (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .wr_data_in   (cmp),
    .wr_valid_in  (1'b1),
    .wr_ready_out (fifo_rdy),
    .rd_data_out  (fifo_dat),
    .rd_valid_out (fifo_v),
    .rd_ready_in  (1'b1)
  );
  assign frame_overflow_out = ~fifo_rdy;

  // Stagger: channel n waits n unit steps; 3 cycles covers the slow supply
  reg [3*NCH-1:0] dly_q [0:NCH-1];
  wire [1:0] step = low_supply_in ? 2'(`LPSL_DELAY_3V3_CYC) : 2'(`LPSL_DELAY_5V_CYC);
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : g_dly
      always @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          dly_q[gi] <= {(3*NCH){1'b0}};
        else
          dly_q[gi] <= {dly_q[gi][3*NCH-2:0], fifo_v & fifo_dat[gi]};
      end
      always @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          on_q[gi] <= 1'b0;
        else if (lat_v_q)
          on_q[gi] <= 1'b0;
        else if (gi == 0)
          on_q[gi] <= fifo_v & fifo_dat[gi];
        else
          on_q[gi] <= dly_q[gi][gi*step - 1];
      end
    end
  endgenerate

  assign channel_sinks_out      = 16'h0000;
  assign channel_sinks_oe_b_out = ~on_q;
endmodule // lpsl_top

/* bench/lpsl_ctrl_model.sv */
// Purpose: Display controller model driving shift, data and strobe pins
// Assumes: Shift clock period 125 ns, clock stands low between frames
// Notes:   Captures the chain output just before every shift clock edge
`timescale 1ns/10ps
module lpsl_ctrl_model (
  output logic      sck_out,
  output logic      sdi_out,
  output logic      lat_out,
  input  wire logic sdo_in
);
  logic [255:0] rb; // Chain output seen before each rise
  logic [255:0] fb; // Chain output seen before each fall

  // Pins idle low after power-up
  initial
  begin
    sck_out = 1'b0;
    sdi_out = 1'b0;
    lat_out = 1'b0;
  end

  // One frame of 256 bits, MSB of channel 15 first, then a latch pulse
  task automatic send(input logic [255:0] d);
    for (int i = 255; i >= 0; i--)
    begin
      sdi_out = d[i];
      #62.5;
      rb[i] = sdo_in;
      sck_out = 1'b1;
      #62.5;
      fb[i] = sdo_in;
      sck_out = 1'b0;
    end
    // Released data line shows the inverse so a stale value never matches
    sdi_out = ~sdi_out;
    #100 lat_out = 1'b1;
    #100 lat_out = 1'b0;
    #200;
  endtask
endmodule // lpsl_ctrl_model

/* bench/lpsl_top_monitor.sv */
// Purpose: Port-level checks on the PWM shift/latch top
// Assumes: Pin ages saturate at 15 core cycles
// Notes:   Bound into every lpsl_top instance
`timescale 1ns/10ps
module lpsl_top_monitor (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        serial_data_in,
  input wire        shift_clock_in,
  input wire        latch_strobe_in,
  input wire        grayscale_clock_in,
  input wire        falling_edge_out_mode_in,
  input wire        single_cycle_mode_in,
  input wire        external_counter_clock_mode_in,
  input wire        low_supply_in,
  input wire [15:0] open_sense_in,
  input wire        serial_data_out,
  input wire [15:0] channel_sinks_oe_b_out,
  input wire [15:0] channel_sinks_out,
  input wire [15:0] open_error_out,
  input wire        frame_overflow_out
);
  reg       sck_q;       // Shift clock copy
  reg       lat_q;       // Strobe copy
  reg [3:0] act_age_q;   // Cycles since shift clock or strobe moved
  reg [3:0] sense_age_q; // Cycles since any open sense
  reg [3:0] on_age_q;    // Cycles since any sink conducted

  function [3:0] sat(input [3:0] a);
    sat = (a == 4'hF) ? a : a + 4'h1;
  endfunction

  // Saturating ages keep long quiet spans cheap
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sck_q <= 1'b0;
      lat_q <= 1'b0;
      act_age_q <= 4'hF;
      sense_age_q <= 4'hF;
      on_age_q <= 4'hF;
    end
    else
    begin
      sck_q <= shift_clock_in;
      lat_q <= latch_strobe_in;
      act_age_q <= ({sck_q, lat_q} != {shift_clock_in, latch_strobe_in}) ? 4'h0 : sat(act_age_q);
      sense_age_q <= (|open_sense_in) ? 4'h0 : sat(sense_age_q);
      on_age_q <= (~&channel_sinks_oe_b_out) ? 4'h0 : sat(on_age_q);
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_strobe_off: assert property (latch_strobe_in [*8] |-> &channel_sinks_oe_b_out)
    else $error("sink on while strobe high");
  a_strobe_hold: assert property ($fell(channel_sinks_oe_b_out[0]) |->
    !latch_strobe_in && !$past(latch_strobe_in))
    else $error("sink turned on during strobe");
  a_sink_low: assert property (channel_sinks_out == 16'h0000)
    else $error("open drain level not low");
  a_sdo_timing: assert property ($changed(serial_data_out) |-> act_age_q < 4'hA)
    else $error("chain output moved without an edge");
  a_no_overflow: assert property (!frame_overflow_out)
    else $error("frame buffer overflow");
  a_err_cause: assert property ($rose(|open_error_out) |-> sense_age_q < 4'hC)
    else $error("open error without sense");
  a_err_clear: assert property ($fell(|open_error_out) |-> on_age_q < 4'hC)
    else $error("open error cleared without sample");
  a_stagger_hi: assert property ($fell(channel_sinks_oe_b_out[0]) && !low_supply_in |->
    ##2 $fell(channel_sinks_oe_b_out[1]))
    else $error("two cycle stagger broken");
  a_stagger_lo: assert property ($fell(channel_sinks_oe_b_out[0]) && low_supply_in |->
    ##3 $fell(channel_sinks_oe_b_out[1]))
    else $error("three cycle stagger broken");

  c_sink_on: cover property ($fell(channel_sinks_oe_b_out[0]));
  c_err_set: cover property ($rose(|open_error_out));
  c_fall_out: cover property ($changed(serial_data_out) && falling_edge_out_mode_in);
endmodule // lpsl_top_monitor

bind lpsl_top lpsl_top_monitor u_mon (.*);

/* bench/lpsl_top_tb.sv */
// Purpose: Self-checking bench for the PWM shift/latch top
// Assumes: Expected chain data built from the word tables; duty from fixed low-bit masks per step
// Notes:   Channel 3 is given an open load to exercise the flag
`timescale 1ns/10ps
module lpsl_top_tb;
  logic         clk_in = 1'b0;
  logic         rst_b_in = 1'b0;
  logic         grayscale_clock = 1'b0;  // Grayscale clock pin
  logic         falling_edge_out_mode = 1'b0;  // Falling edge output mode
  logic         single_cycle_mode = 1'b0;  // Single cycle mode
  logic         external_counter_clock_mode = 1'b0;  // External counter clock
  logic         lowv = 1'b0; // Low supply step
  logic [15:0]  open_mask = 16'h0000; // Channels with open load
  wire          sck, sdi, lat, sdo, ovf;
  wire  [15:0]  oe_b, sinks, err;
  int           num_errors = 0;
  int           comparisons = 0;
  logic [15:0]  wa [16];
  logic [15:0]  wb [16];
  logic [255:0] fa, fbv, ea, eb;

  always #5 clk_in = ~clk_in;

  lpsl_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .serial_data_in(sdi),
    .shift_clock_in(sck), .latch_strobe_in(lat), .grayscale_clock_in(grayscale_clock),
    .falling_edge_out_mode_in(falling_edge_out_mode), .single_cycle_mode_in(single_cycle_mode),
    .external_counter_clock_mode_in(external_counter_clock_mode), .low_supply_in(lowv),
    .open_sense_in(open_mask & ~oe_b), .serial_data_out(sdo),
    .channel_sinks_oe_b_out(oe_b), .channel_sinks_out(sinks),
    .open_error_out(err), .frame_overflow_out(ovf));
  lpsl_ctrl_model u_ctrl (.sck_out(sck), .sdi_out(sdi), .lat_out(lat), .sdo_in(sdo));

  task check(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task gpulse(input int n);
    repeat (n)
    begin
      grayscale_clock = 1'b1;
      step(5);
      grayscale_clock = 1'b0;
      step(5);
    end
  endtask

  // Frame vector and expected chain readback with flag in each LSB
  task mk(input logic [15:0] w [16], input logic [15:0] bad,
          output logic [255:0] f, output logic [255:0] e);
    for (int k = 0; k < 16; k++)
    begin
      f[16*k +: 16] = w[k];
      e[16*k +: 16] = {w[k][15:1], ~bad[k]};
    end
  endtask

  // Watchdog
  initial
  begin
    #2000000;
    num_errors++;
    final_report;
  end

  initial
  begin
    void'($urandom(32'hCE29));
    step(2);
    rst_b_in = 1'b1;
    step(4);
    for (int k = 0; k < 16; k++)
    begin
      wa[k] = $urandom;
      wb[k] = 16'(4 * k + 2);
    end
    lowv = $urandom;
    mk(wa, 16'h0008, fa, ea);
    mk(wb, 16'h0008, fbv, eb);
    u_ctrl.send(fa);
    open_mask = 16'h0008;
    step(300);
    check("open_error", err, 16'h0008);
    u_ctrl.send(fa);
    falling_edge_out_mode = 1'b1;
    single_cycle_mode = 1'b1;
    external_counter_clock_mode = 1'b1;
    u_ctrl.send(fbv);
    check("readback rise", u_ctrl.rb, ea);
    check("readback fall", {u_ctrl.fb[255:1], 1'b0}, {ea[254:0], 1'b0});
    step(60);
    check("sinks idle", oe_b, 16'hFFFF);
    for (int j = 1; j <= 4; j++)
    begin
      gpulse(4);
      step(60);
      check("sinks duty", oe_b, (16'h0001 << j) - 16'h0001);
    end
    u_ctrl.send(fbv);
    check("fem rise", u_ctrl.rb, eb);
    check("fem fall", u_ctrl.fb, eb);
    final_report;
  end
endmodule // lpsl_top_tb
